// *** mcu_bus_pkg.sv ***
// Constants for the host bus interface and address decode block.
// Assumes one 250 MHz clock; all host strobes arrive synchronous to it.
package mcu_bus_pkg;
	localparam int NUM_IN = 61;
	localparam int NUM_SEL = 8;
	localparam int NUM_MC = 24;
	localparam int NUM_ROM = 4;
	localparam int SEL_SRAM = 4;
	localparam int SEL_IO = 5;
	localparam int SEL_PERIPH = 6;
	localparam int SRAM_AW = 10;
	localparam int ROM_AW = 12;
	localparam int PAGE_W = 4;
	localparam logic [3:0] PAGE_RST = 4'h0;
	localparam logic [7:0] PAGE_OFS = 8'hE0;
	localparam logic [7:0] MC_LO_OFS = 8'hE2;
	localparam logic [7:0] MC_HI_OFS = 8'hE4;
	localparam int STANDBY_NS = 100;
	localparam int CLK_PERIOD_NS = 4;
	localparam int IDLE_CYC = (STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] IDLE_LAST = 6'(IDLE_CYC - 1);
endpackage

// *** word_mem.sv ***
`timescale 1ns/1ns
// Single-port word memory with byte enables and registered read data.
// Assumes the caller holds the address steady for a read.
module word_mem #(
	parameter int AW = 10
) (
	input wire logic i_clk,
	input wire logic i_ce,
	input wire logic i_en,
	input wire logic i_we,
	input wire logic [1:0] i_be,
	input wire logic [AW-1:0] i_addr,
	input wire logic [15:0] i_wdata,
	output logic [15:0] o_rdata
);
	logic [15:0] mem [2**AW];

	always_ff @(posedge i_clk) begin
		if (i_ce && i_en) begin
			if (i_we && i_be[0])
				mem[i_addr][7:0] <= i_wdata[7:0];
			if (i_we && i_be[1])
				mem[i_addr][15:8] <= i_wdata[15:8];
			o_rdata <= mem[i_addr];
		end
	end
endmodule

// *** mcu_bus_decode.sv ***
`timescale 1ns/1ns
// Host bus port, address decode arrays, page register and memories.
// Assumes host strobes are synchronous and last several clock cycles.
module mcu_bus_decode
	import mcu_bus_pkg::*;
(
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_SYS_RST,
	input wire logic I_CE,
	// Configuration
	input wire logic i_mux_mode,
	input wire logic i_bus16,
	input wire logic i_fast_power,
	input wire logic i_porta_addr_in,
	input wire logic i_addr_out_en,
	input wire logic [NUM_SEL*NUM_IN-1:0] i_dec_care,
	input wire logic [NUM_SEL*NUM_IN-1:0] i_dec_match,
	input wire logic [NUM_MC*NUM_IN-1:0] i_mc_care,
	input wire logic [NUM_MC*NUM_IN-1:0] i_mc_match,
	// ROM programming
	input wire logic i_prog_we,
	input wire logic [1:0] i_prog_blk,
	input wire logic [ROM_AW-1:0] i_prog_addr,
	input wire logic [15:0] i_prog_data,
	// Host bus
	input wire logic i_ale,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic i_bhe_n,
	input wire logic [15:0] i_adio,
	output logic [15:0] o_adio,
	output logic o_adio_oe,
	// Ports
	input wire logic [7:0] i_port_a,
	input wire logic [7:0] i_port_b,
	input wire logic [7:0] i_port_c,
	input wire logic [7:0] i_port_d,
	input wire logic [4:0] i_port_e,
	output logic [7:0] o_port_c,
	output logic [7:0] o_port_d,
	output logic o_port_cd_oe,
	output logic [7:0] o_port_a,
	output logic [7:0] o_port_b,
	output logic [7:0] o_port_e,
	// Status
	output logic [NUM_SEL-1:0] o_select,
	output logic [PAGE_W-1:0] o_page,
	output logic o_standby
);
	logic [15:0] addr;
	logic bhe;
	logic ale_q;
	logic wr_q;
	logic [15:0] wdata_q;
	logic [PAGE_W-1:0] page;
	logic [NUM_SEL-1:0] sel;
	logic [NUM_SEL-1:0] next_sel;
	logic [NUM_MC-1:0] mc;
	logic [NUM_MC-1:0] next_mc;
	logic [NUM_IN-1:0] bus;
	logic [NUM_IN-1:0] bus_q;
	logic [5:0] idle_cnt;
	logic [7:0] hi_addr;
	logic commit;
	logic [1:0] be;
	logic [15:0] wr_word;
	logic [15:0] rom_rdata [NUM_ROM];
	logic [15:0] sram_rdata;
	logic [15:0] io_rdata;
	logic [15:0] next_word;
	logic [15:0] raw_word;
	logic read_on;

	// High address lines enter the bus only when port A is an address port
	assign hi_addr = i_porta_addr_in ? i_port_a : 8'h00;

	// One shared input bus feeds every array
	assign bus = {i_port_e, i_port_d, i_port_c, i_port_b,
		i_ale, ~i_rd_n, ~i_wr_n, bhe, page, hi_addr, addr};

	// Address capture on the strobe's falling edge, else follow the port
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			ale_q <= 1'b0;
			addr <= 16'h0000;
			bhe <= 1'b0;
		end else if (I_CE) begin
			ale_q <= i_ale;
			if (!i_mux_mode) begin
				addr <= i_adio;
				bhe <= ~i_bhe_n;
			end else if (ale_q && !i_ale) begin
				addr <= i_adio;
				bhe <= ~i_bhe_n;
			end
		end
	end

	// Decode selects and macrocells, one product term each
	genvar k;
	generate
		for (k = 0; k < NUM_SEL; k++) begin : g_dec
			assign next_sel[k] = &(~i_dec_care[k*NUM_IN +: NUM_IN]
				| ~(bus ^ i_dec_match[k*NUM_IN +: NUM_IN]));
		end
		for (k = 0; k < NUM_MC; k++) begin : g_mc
			assign next_mc[k] = &(~i_mc_care[k*NUM_IN +: NUM_IN]
				| ~(bus ^ i_mc_match[k*NUM_IN +: NUM_IN]));
		end
	endgenerate

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			sel <= '0;
			mc <= '0;
		end else if (I_CE) begin
			sel <= next_sel;
			mc <= next_mc;
		end
	end

	// Write strobe tracking; data kept from the last low-strobe cycle
	assign wr_word = i_mux_mode ? i_adio : {i_port_d, i_port_c};
	assign commit = wr_q && i_wr_n;

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			wr_q <= 1'b0;
			wdata_q <= 16'h0000;
		end else if (I_CE) begin
			wr_q <= ~i_wr_n;
			if (!i_wr_n)
				wdata_q <= wr_word;
		end
	end

	// Byte lanes: a byte bus steers by address bit 0
	always_comb begin
		if (i_bus16)
			be = {bhe, ~addr[0]};
		else
			be = addr[0] ? 2'b10 : 2'b01;
	end

	// Page register, written through the I/O select
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			page <= PAGE_RST;
		end else if (I_CE) begin
			if (commit && sel[SEL_IO] && addr[7:0] == PAGE_OFS && be[0])
				page <= wdata_q[PAGE_W-1:0];
		end
	end

	// Memories; a byte bus repeats the low byte on both lanes
	logic [15:0] mem_wdata;
	assign mem_wdata = i_bus16 ? wdata_q : {wdata_q[7:0], wdata_q[7:0]};

	generate
		for (k = 0; k < NUM_ROM; k++) begin : g_rom
			logic prog_hit;
			assign prog_hit = i_prog_we && i_prog_blk == 2'(k);
			// Only the programming port writes; the host only reads
			word_mem #(.AW(ROM_AW)) u_rom (
				.i_clk(I_SYS_CLK),
				.i_ce(I_CE),
				.i_en(prog_hit || sel[k]),
				.i_we(prog_hit),
				.i_be(2'b11),
				.i_addr(prog_hit ? i_prog_addr : addr[ROM_AW:1]),
				.i_wdata(i_prog_data),
				.o_rdata(rom_rdata[k])
			);
		end
	endgenerate

	word_mem #(.AW(SRAM_AW)) u_sram (
		.i_clk(I_SYS_CLK),
		.i_ce(I_CE),
		.i_en(sel[SEL_SRAM]),
		.i_we(commit),
		.i_be(be),
		.i_addr(addr[SRAM_AW:1]),
		.i_wdata(mem_wdata),
		.o_rdata(sram_rdata)
	);

	// Internal I/O space: page and macrocell readback
	always_comb begin
		case (addr[7:0])
			PAGE_OFS: io_rdata = {12'h000, page};
			MC_LO_OFS: io_rdata = mc[15:0];
			MC_HI_OFS: io_rdata = {8'h00, mc[23:16]};
			default: io_rdata = 16'h0000;
		endcase
	end

	// Read data select; the I/O space answers on word lanes
	always_comb begin
		raw_word = 16'h0000;
		if (sel[SEL_IO])
			raw_word = io_rdata;
		else if (sel[SEL_SRAM])
			raw_word = sram_rdata;
		for (int i = 0; i < NUM_ROM; i++)
			if (sel[i])
				raw_word = rom_rdata[i];
		if (i_bus16 || sel[SEL_IO])
			next_word = raw_word;
		else
			next_word = {8'h00, addr[0] ? raw_word[15:8] : raw_word[7:0]};
	end

	// Fresh select too: the held one lags a new address by a cycle
	assign read_on = !i_rd_n && |sel && |next_sel;

	// Output drivers, registered: released on the clock edge after the strobe or select ends
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			o_adio <= 16'h0000;
			o_adio_oe <= 1'b0;
			o_port_c <= 8'h00;
			o_port_d <= 8'h00;
			o_port_cd_oe <= 1'b0;
		end else if (I_CE) begin
			o_adio <= next_word;
			o_port_c <= next_word[7:0];
			o_port_d <= next_word[15:8];
			o_adio_oe <= read_on && i_mux_mode;
			o_port_cd_oe <= read_on && !i_mux_mode;
		end
	end

	// Ports A, B and E carry macrocells; B may carry low address instead
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			o_port_a <= 8'h00;
			o_port_b <= 8'h00;
			o_port_e <= 8'h00;
		end else if (I_CE) begin
			o_port_a <= mc[7:0];
			o_port_e <= mc[23:16];
			if (i_addr_out_en)
				o_port_b <= addr[7:0];
			else
				o_port_b <= mc[15:8];
		end
	end

	// Quiet-bus timer; fast power mode never idles the arrays
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			bus_q <= '0;
			idle_cnt <= 6'h00;
			o_standby <= 1'b0;
		end else if (I_CE) begin
			bus_q <= bus;
			if (bus != bus_q)
				idle_cnt <= 6'h00;
			else if (idle_cnt != IDLE_LAST)
				idle_cnt <= idle_cnt + 6'h01;
			o_standby <= !i_fast_power && bus == bus_q
				&& idle_cnt == IDLE_LAST;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			o_select <= '0;
			o_page <= PAGE_RST;
		end else if (I_CE) begin
			o_select <= sel;
			o_page <= page;
		end
	end

	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_SYS_RST || !I_CE);

	sequence s_rd_sel;
		(!i_rd_n && |sel && i_mux_mode) [*2];
	endsequence

	sequence s_page_rd;
		(!i_rd_n && sel[SEL_IO] && addr[7:0] == PAGE_OFS) [*2];
	endsequence

	property p_addr_latch;
		$fell(i_ale) && i_mux_mode && I_CE |=> addr == $past(i_adio);
	endproperty
	a_addr_latch: assert property (p_addr_latch)
		else $error("address not captured at strobe fall");

	property p_read_drive;
		s_rd_sel |=> o_adio_oe && !o_port_cd_oe;
	endproperty
	a_read_drive: assert property (p_read_drive)
		else $error("read data not driven on address/data lines");

	property p_float;
		(~|sel) |=> !o_adio_oe && !o_port_cd_oe;
	endproperty
	a_float: assert property (p_float)
		else $error("driver on with no block selected");

	property p_lanes;
		!(o_adio_oe && o_port_cd_oe);
	endproperty
	a_lanes: assert property (p_lanes)
		else $error("both data paths driven");

	property p_release;
		$rose(i_rd_n) |=> !o_adio_oe ##1 !o_adio_oe;
	endproperty
	a_release: assert property (p_release)
		else $error("bus not released after read strobe");

	property p_rom_en;
		!sel[1] && !(i_prog_we && i_prog_blk == 2'h1)
			|=> $stable(rom_rdata[1]);
	endproperty
	a_rom_en: assert property (p_rom_en)
		else $error("rom block read without its select");

	property p_page_write;
		commit && sel[SEL_IO] && addr[7:0] == PAGE_OFS && be[0]
			|=> ##1 o_page == $past(wdata_q[3:0], 2);
	endproperty
	a_page_write: assert property (p_page_write)
		else $error("page value not stored");

	property p_page_read;
		s_page_rd |=> o_adio[15:4] == 12'h000 && o_adio[3:0] == $past(page);
	endproperty
	a_page_read: assert property (p_page_read)
		else $error("page readback wrong");

	property p_addr_out;
		i_addr_out_en |=> o_port_b == $past(addr[7:0]);
	endproperty
	a_addr_out: assert property (p_addr_out)
		else $error("latched address not on port B");

	property p_standby;
		!i_fast_power && bus == bus_q && idle_cnt == IDLE_LAST
			|=> o_standby;
	endproperty
	a_standby: assert property (p_standby)
		else $error("standby not entered after quiet bus");

	property p_wake;
		bus != bus_q || i_fast_power |=> !o_standby;
	endproperty
	a_wake: assert property (p_wake)
		else $error("standby held with active bus");
endmodule

// *** mcu_host_model.sv ***
`timescale 1ns/1ns
// Host bus master model: one read or write cycle per call.
// Assumes the bench owns the clock and the bus mode level.
module mcu_host_model (
	input wire logic i_clk,
	input wire logic i_mux,
	input wire logic [15:0] i_adio_rd,
	input wire logic [15:0] i_cd_rd,
	input wire logic i_any_oe,
	output logic o_ale,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic o_bhe_n,
	output logic [15:0] o_adio
);
	initial begin
		o_ale = 1'h0;
		o_rd_n = 1'h1;
		o_wr_n = 1'h1;
		o_bhe_n = 1'h1;
		o_adio = 16'h0000;
	end

	task automatic cycle(input logic wr, input logic [15:0] a,
		input logic [15:0] d, input logic bn, output logic [15:0] q,
		output logic oe);
		oe = 1'h0;
		@(posedge i_clk) #1;
		o_ale = 1'h1;
		o_adio = a; // Address on the shared port
		o_bhe_n = bn;
		@(posedge i_clk) #1;
		o_ale = 1'h0;
		@(posedge i_clk) #1;
		// Writes put data in either mode; a non-mux read keeps the address up, a mux read drives its inverse
		if (wr)
			o_adio = d;
		else if (i_mux)
			o_adio = ~a;
		for (int i = 0; i < 6; i++) begin
			if (wr)
				o_wr_n = 1'h0;
			else
				o_rd_n = 1'h0;
			@(posedge i_clk) #1;
			oe = oe | i_any_oe;
		end
		q = i_mux ? i_adio_rd : i_cd_rd; // Data lanes per mode
		o_wr_n = 1'h1;
		o_rd_n = 1'h1;
		// Address and data held one cycle past the strobe
		@(posedge i_clk) #1;
		o_adio = ~o_adio;
		o_bhe_n = ~bn;
	endtask
endmodule

// *** mcu_bus_decode_tb_top.sv ***
`timescale 1ns/1ns
// Self-checking bench for the host bus port and address decode.
// Assumes mcu_host_model drives every host strobe.
module mcu_bus_decode_tb_top;
	import mcu_bus_pkg::*;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic mux = 1'h1;
	logic fast = 1'h1;
	logic aout = 1'h0;
	logic [NUM_SEL*NUM_IN-1:0] care = '0;
	logic [NUM_SEL*NUM_IN-1:0] match = '0;
	logic pwe = 1'h0;
	logic [1:0] pblk = 2'h0;
	logic [ROM_AW-1:0] paddr = '0;
	logic [15:0] pdat = 16'h0000;
	logic [7:0] pins = 8'h00;
	logic pa = 1'h0;
	logic b16 = 1'h1;
	logic [7:0] pa_out, pe_out;
	logic ale, rd_n, wr_n, bhe_n, oe, cd_oe, seen, stby;
	logic [15:0] adio, o_adio, q;
	logic [7:0] pc, pd, pb, sel;
	logic [3:0] page;
	int err_count = 0;
	int cmp_count = 0;

	always #2 clk = ~clk;

	mcu_bus_decode dut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_CE(1'h1),
		.i_mux_mode(mux), .i_bus16(b16), .i_fast_power(fast),
		.i_porta_addr_in(pa), .i_addr_out_en(aout),
		.i_dec_care(care), .i_dec_match(match), .i_mc_care('0),
		.i_mc_match('0), .i_prog_we(pwe), .i_prog_blk(pblk),
		.i_prog_addr(paddr), .i_prog_data(pdat), .i_ale(ale),
		.i_rd_n(rd_n), .i_wr_n(wr_n), .i_bhe_n(bhe_n), .i_adio(adio),
		.o_adio(o_adio), .o_adio_oe(oe), .i_port_a(pins),
		.i_port_b(pins), .i_port_c(pins), .i_port_d(pins),
		.i_port_e(pins[4:0]), .o_port_c(pc), .o_port_d(pd),
		.o_port_cd_oe(cd_oe), .o_port_a(pa_out), .o_port_b(pb),
		.o_port_e(pe_out),
		.o_select(sel), .o_page(page), .o_standby(stby));

	mcu_host_model host (.i_clk(clk), .i_mux(mux), .i_adio_rd(o_adio),
		.i_cd_rd({pd, pc}), .i_any_oe(oe | cd_oe), .o_ale(ale),
		.o_rd_n(rd_n), .o_wr_n(wr_n), .o_bhe_n(bhe_n), .o_adio(adio));

	task automatic check(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic term(input int k, input int lo, input int w,
		input logic [7:0] v);
		for (int i = 0; i < w; i++) begin
			care[k*NUM_IN+lo+i] = 1'h1;
			match[k*NUM_IN+lo+i] = v[i];
		end
	endtask

	task automatic load(input logic [1:0] b, input logic [15:0] d);
		@(posedge clk) #1;
		pwe = 1'h1;
		pblk = b;
		paddr = 12'hA36;
		pdat = d;
		// Second edge reads the word back, so the output is never unknown
		repeat (2) @(posedge clk);
		#1 pwe = 1'h0;
	endtask

	task automatic t_sram;
		aout = 1'h1;
		host.cycle(1'h1, 16'h8476, 16'h5A27, 1'h0, q, seen);
		host.cycle(1'h0, 16'h8476, 16'h0000, 1'h0, q, seen);
		check(q, 16'h5A27);
		check({15'h0000, seen}, 16'h0001);
		check({15'h0000, oe}, 16'h0000);
		check({8'h00, sel}, 16'h0010);
		check({8'h00, pb}, 16'h0076);
		$display("test sram done");
	endtask

	task automatic t_rom;
		host.cycle(1'h0, 16'h146C, 16'h0000, 1'h0, q, seen);
		check(q, 16'h0123);
		host.cycle(1'h1, 16'hC0E0, 16'h0009, 1'h1, q, seen);
		repeat (3) @(posedge clk);
		#1 check({12'h000, page}, 16'h0009);
		host.cycle(1'h0, 16'hC0E0, 16'h0000, 1'h0, q, seen);
		check(q, 16'h0009);
		host.cycle(1'h0, 16'h146C, 16'h0000, 1'h0, q, seen);
		check(q, 16'h4567);
		check({8'h00, sel}, 16'h0002);
		$display("test rom page done");
	endtask

	task automatic t_nosel;
		host.cycle(1'h0, 16'h4000, 16'h0000, 1'h0, q, seen);
		check({15'h0000, seen}, 16'h0000);
		check({8'h00, sel}, 16'h0000);
		$display("test no select done");
	endtask

	task automatic t_nmux;
		mux = 1'h0;
		host.cycle(1'h0, 16'h8476, 16'h0000, 1'h0, q, seen);
		check(q, 16'h5A27);
		check({15'h0000, seen}, 16'h0001);
		mux = 1'h1;
		$display("test non-mux done");
	endtask

	task automatic t_byte;
		b16 = 1'h0;
		host.cycle(1'h1, 16'h8477, 16'h00C3, 1'h1, q, seen);
		host.cycle(1'h0, 16'h8477, 16'h0000, 1'h1, q, seen);
		check(q, 16'h00C3);
		host.cycle(1'h0, 16'h8476, 16'h0000, 1'h1, q, seen);
		check(q, 16'h0027);
		b16 = 1'h1;
		host.cycle(1'h0, 16'h8476, 16'h0000, 1'h0, q, seen);
		check(q, 16'hC327);
		$display("test byte bus done");
	endtask

	task automatic t_mc;
		// No cared inputs, so every macrocell term is true
		host.cycle(1'h0, 16'hC0E2, 16'h0000, 1'h0, q, seen);
		check(q, 16'hFFFF);
		host.cycle(1'h0, 16'hC0E4, 16'h0000, 1'h0, q, seen);
		check(q, 16'h00FF);
		check({pe_out, pa_out}, 16'hFFFF);
		$display("test macrocell done");
	endtask

	task automatic t_hi;
		pins = 8'h05;
		pa = 1'h1;
		repeat (3) @(posedge clk);
		#1 check({15'h0000, sel[6]}, 16'h0001);
		pa = 1'h0;
		repeat (3) @(posedge clk);
		#1 check({15'h0000, sel[6]}, 16'h0000);
		pins = 8'h00;
		$display("test high address done");
	endtask

	task automatic t_stby;
		fast = 1'h0;
		repeat (30) @(posedge clk);
		#1 check({15'h0000, stby}, 16'h0001);
		pins = 8'h55;
		repeat (2) @(posedge clk);
		#1 check({15'h0000, stby}, 16'h0000);
		fast = 1'h1;
		$display("test standby done");
	endtask

	task automatic test_done;
		$display("compares=%0d mismatches=%0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		// Spare selects need both strobes at once, so never fire
		foreach (match[i]) match[i] = 1'h0;
		term(0, 13, 3, 8'h00);
		term(0, 24, 4, 8'h00);
		term(1, 13, 3, 8'h00);
		term(1, 24, 4, 8'h09);
		term(4, 13, 3, 8'h04);
		term(5, 8, 8, 8'hC0);
		for (int k = 2; k < 8; k++) begin
			if (k == 2 || k == 3 || k == 7)
				term(k, 29, 2, 8'h03);
		end
		// Select 6 watches the high address pins only
		term(6, 16, 3, 8'h05);
		repeat (8) @(posedge clk);
		#1 rst = 1'h0;
		load(2'h0, 16'h0123);
		load(2'h1, 16'h4567);
		t_sram();
		t_rom();
		t_nosel();
		t_nmux();
		t_byte();
		t_mc();
		t_hi();
		t_stby();
		test_done();
	end

	initial begin
		#20000;
		err_count++;
		test_done();
	end
endmodule
